// >>> hdl/gec_counter_top.v
// Two-channel gated event counter with its register port and shared internal timebase
//
// Overview of operation
// - Each qualifying source transition counts once.
// - One config write sets one or both counters.
// - Mode 0 ignores gate, counts after start.
// - Mode 1 counts while gate high.
// - Mode 2 counts while gate low.
// - Mode 3 starts counting at gate rising edge.
// - Mode 4 starts counting at gate falling edge.
// - Source edge 0 rising, 1 falling.
// - Timebase off counts pins, else internal cycles.
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
`include "gec_consts.vh"

module gec_counter_top (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // Register port
  input wire [`GEC_ADDR_W-1:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [31:0] regRdData_q,
  // Counter pins
  input wire [1:0] counterEventInput,
  input wire [1:0] counterGateInput
);

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [`GEC_CFG_W-1:0] cfg0_q;
  reg [`GEC_CFG_W-1:0] cfg1_q;
  reg [`GEC_TBDIV_W-1:0] tbDiv_q;
  reg [`GEC_TBDIV_W-1:0] tbCnt_q;
  wire timebaseTick;
  wire [1:0] startCmd;
  wire [1:0] stopCmd;
  wire [1:0] clearCmd;
  wire [1:0] armed;
  wire [1:0] counting;
  wire [`GEC_COUNT_W-1:0] count0;
  wire [`GEC_COUNT_W-1:0] count1;
  wire cfgWr0;
  wire cfgWr1;
  wire cmdWr;

  // A write with the both-bit set at either config offset loads both channels at once
  assign cfgWr0 = regWrStb && (regAddr == `GEC_OFS_CFG0 ||
                  (regAddr == `GEC_OFS_CFG1 && regWrData[`GEC_CFG_BOTH_BIT]));
  assign cfgWr1 = regWrStb && (regAddr == `GEC_OFS_CFG1 ||
                  (regAddr == `GEC_OFS_CFG0 && regWrData[`GEC_CFG_BOTH_BIT]));
  assign cmdWr = regWrStb && (regAddr == `GEC_OFS_CMD);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfg0_q <= `GEC_CFG_RESET;
      cfg1_q <= `GEC_CFG_RESET;
      tbDiv_q <= `GEC_TBDIV_RESET;
    end else begin
      if (cfgWr0) begin
        cfg0_q <= regWrData[`GEC_CFG_W-1:0];
      end
      if (cfgWr1) begin
        cfg1_q <= regWrData[`GEC_CFG_W-1:0];
      end
      if (regWrStb && regAddr == `GEC_OFS_TBDIV) begin
        tbDiv_q <= regWrData[`GEC_TBDIV_W-1:0];
      end
    end
  end

  // Command bits are pulses; nothing is stored, so a read of this offset gives zero
  assign startCmd = cmdWr ? {regWrData[`GEC_CMD_START1], regWrData[`GEC_CMD_START0]} : 2'h0;
  assign stopCmd = cmdWr ? {regWrData[`GEC_CMD_STOP1], regWrData[`GEC_CMD_STOP0]} : 2'h0;
  assign clearCmd = cmdWr ? {regWrData[`GEC_CMD_CLEAR1], regWrData[`GEC_CMD_CLEAR0]} : 2'h0;

  // ----------------------------------------------------------------
  // Internal timebase
  // ----------------------------------------------------------------
  // Tick every tbDiv+1 clocks; shared by both channels so paired counts stay aligned
  assign timebaseTick = (tbCnt_q == tbDiv_q);

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tbCnt_q <= `GEC_TBDIV_RESET;
    end else if (timebaseTick) begin
      tbCnt_q <= `GEC_TBDIV_RESET;
    end else begin
      tbCnt_q <= tbCnt_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Counter channels
  // ----------------------------------------------------------------
  gec_counter_chan chan0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .counterEventInput(counterEventInput[0]),
    .counterGateInput(counterGateInput[0]),
    .timebaseTick(timebaseTick),
    .gateMode(cfg0_q[`GEC_CFG_MODE_MSB:`GEC_CFG_MODE_LSB]),
    .sourceEdge(cfg0_q[`GEC_CFG_EDGE_BIT]),
    .useTimebase(cfg0_q[`GEC_CFG_TB_BIT]),
    .startCmd(startCmd[0]),
    .stopCmd(stopCmd[0]),
    .clearCmd(clearCmd[0]),
    .count_q(count0),
    .armed(armed[0]),
    .counting(counting[0])
  );

  gec_counter_chan chan1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .counterEventInput(counterEventInput[1]),
    .counterGateInput(counterGateInput[1]),
    .timebaseTick(timebaseTick),
    .gateMode(cfg1_q[`GEC_CFG_MODE_MSB:`GEC_CFG_MODE_LSB]),
    .sourceEdge(cfg1_q[`GEC_CFG_EDGE_BIT]),
    .useTimebase(cfg1_q[`GEC_CFG_TB_BIT]),
    .startCmd(startCmd[1]),
    .stopCmd(stopCmd[1]),
    .clearCmd(clearCmd[1]),
    .count_q(count1),
    .armed(armed[1]),
    .counting(counting[1])
  );

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data stand one cycle after the read strobe and only then; unmapped offsets read zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData_q <= 32'h00000000;
    end else if (!regRdStb) begin
      regRdData_q <= 32'h00000000;
    end else if (regAddr == `GEC_OFS_CFG0) begin
      regRdData_q <= {27'h0000000, cfg0_q};
    end else if (regAddr == `GEC_OFS_CFG1) begin
      regRdData_q <= {27'h0000000, cfg1_q};
    end else if (regAddr == `GEC_OFS_STATUS) begin
      regRdData_q <= {28'h0000000, counting, armed};
    end else if (regAddr == `GEC_OFS_COUNT0) begin
      regRdData_q <= count0;
    end else if (regAddr == `GEC_OFS_COUNT1) begin
      regRdData_q <= count1;
    end else if (regAddr == `GEC_OFS_TBDIV) begin
      regRdData_q <= {16'h0000, tbDiv_q};
    end else begin
      regRdData_q <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// >>> pkg/gec_consts.vh
// Register offsets, field positions, reset values and state codes of the gated event counter
`ifndef GEC_CONSTS_VH
`define GEC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define GEC_ADDR_W 8
`define GEC_OFS_CFG0 8'h00
`define GEC_OFS_CMD 8'h04
`define GEC_OFS_STATUS 8'h08
`define GEC_OFS_COUNT0 8'h0c
`define GEC_OFS_COUNT1 8'h10
`define GEC_OFS_TBDIV 8'h14
`define GEC_OFS_CFG1 8'h18

// ----------------------------------------------------------------
// Configuration fields
// ----------------------------------------------------------------
`define GEC_CFG_MODE_LSB 0
`define GEC_CFG_MODE_MSB 2
`define GEC_CFG_EDGE_BIT 3
`define GEC_CFG_TB_BIT 4
`define GEC_CFG_BOTH_BIT 5
`define GEC_CFG_W 5
`define GEC_CFG_RESET 5'h00

// ----------------------------------------------------------------
// Command bits (write-only pulses)
// ----------------------------------------------------------------
`define GEC_CMD_START0 0
`define GEC_CMD_START1 1
`define GEC_CMD_STOP0 2
`define GEC_CMD_STOP1 3
`define GEC_CMD_CLEAR0 4
`define GEC_CMD_CLEAR1 5

// ----------------------------------------------------------------
// Gate modes and source edges
// ----------------------------------------------------------------
`define GEC_MODE_UNGATED 3'h0
`define GEC_MODE_LEVEL_HIGH 3'h1
`define GEC_MODE_LEVEL_LOW 3'h2
`define GEC_MODE_START_RISE 3'h3
`define GEC_MODE_START_FALL 3'h4
`define GEC_EDGE_RISING 1'h0

// ----------------------------------------------------------------
// Widths, reset values, state codes
// ----------------------------------------------------------------
`define GEC_COUNT_W 32
`define GEC_COUNT_RESET 32'h00000000
`define GEC_TBDIV_W 16
`define GEC_TBDIV_RESET 16'h0000
`define GEC_ST_IDLE 3'h1
`define GEC_ST_WAIT 3'h2
`define GEC_ST_RUN 3'h4

`endif

// >>> hdl/gec_counter_chan.v
// One gated event counter channel: input synchronisers, gate state machine and count register
`timescale 1ns/1ns
`default_nettype none
`include "gec_consts.vh"

module gec_counter_chan (
  // Clock and reset
  input wire clk,
  input wire sys_rst,
  // External pins
  input wire counterEventInput,
  input wire counterGateInput,
  // Internal timebase tick
  input wire timebaseTick,
  // Configuration
  input wire [2:0] gateMode,
  input wire sourceEdge,
  input wire useTimebase,
  // Commands, one-cycle pulses
  input wire startCmd,
  input wire stopCmd,
  input wire clearCmd,
  // State
  output reg [`GEC_COUNT_W-1:0] count_q,
  output wire armed,
  output wire counting
);

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  reg evMeta_q, evSync_q, evLast_q;
  reg gtMeta_q, gtSync_q, gtLast_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  wire evEdge;
  wire gateRise;
  wire gateFall;
  wire countEvent;
  wire gateOpen;

  // Two flops per pin, then a third for edge detection; the first is read by nothing else
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evMeta_q <= 1'b0;
      evSync_q <= 1'b0;
      evLast_q <= 1'b0;
      gtMeta_q <= 1'b0;
      gtSync_q <= 1'b0;
      gtLast_q <= 1'b0;
    end else begin
      evMeta_q <= counterEventInput;
      evSync_q <= evMeta_q;
      evLast_q <= evSync_q;
      gtMeta_q <= counterGateInput;
      gtSync_q <= gtMeta_q;
      gtLast_q <= gtSync_q;
    end
  end

  // Selected edge polarity of the event pin, or internal timebase cycles
  assign evEdge = (sourceEdge == `GEC_EDGE_RISING) ? (evSync_q & ~evLast_q) : (~evSync_q & evLast_q);
  assign countEvent = useTimebase ? timebaseTick : evEdge;
  assign gateRise = gtSync_q & ~gtLast_q;
  assign gateFall = ~gtSync_q & gtLast_q;

  // ----------------------------------------------------------------
  // Gate state machine
  // ----------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      `GEC_ST_IDLE: begin
        if (startCmd) begin
          if (gateMode == `GEC_MODE_START_RISE || gateMode == `GEC_MODE_START_FALL) begin
            state_d = `GEC_ST_WAIT;
          end else begin
            state_d = `GEC_ST_RUN;
          end
        end
      end
      `GEC_ST_WAIT: begin
        if (stopCmd) begin
          state_d = `GEC_ST_IDLE;
        end else if (gateMode == `GEC_MODE_START_RISE && gateRise) begin
          state_d = `GEC_ST_RUN;
        end else if (gateMode == `GEC_MODE_START_FALL && gateFall) begin
          state_d = `GEC_ST_RUN;
        end
      end
      `GEC_ST_RUN: begin
        if (stopCmd) begin
          state_d = `GEC_ST_IDLE;
        end
      end
      default: begin
        state_d = `GEC_ST_IDLE;
      end
    endcase
  end

  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= `GEC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Level modes only qualify counting; an edge-start mode stays open once triggered
  assign gateOpen = (gateMode == `GEC_MODE_LEVEL_HIGH) ? gtSync_q :
                    (gateMode == `GEC_MODE_LEVEL_LOW) ? ~gtSync_q : 1'b1;
  assign counting = (state_q == `GEC_ST_RUN) & gateOpen;
  assign armed = (state_q != `GEC_ST_IDLE);

  // ----------------------------------------------------------------
  // Count register
  // ----------------------------------------------------------------
  // Closed gate simply holds the value, so counting resumes where it left off
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count_q <= `GEC_COUNT_RESET;
    end else if (clearCmd) begin
      count_q <= `GEC_COUNT_RESET;
    end else if (counting && countEvent) begin
      count_q <= count_q + 1'b1;
    end
  end

endmodule
`default_nettype wire

// >>> testbench/gec_counter_monitor.sv
// Port-level checker for the gated event counter register port
`timescale 1ns/1ns
`default_nettype none
`include "gec_consts.vh"
module gec_counter_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [`GEC_ADDR_W-1:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [31:0] regRdData_q,
  // Counter pins
  input wire logic [1:0] counterEventInput,
  input wire logic [1:0] counterGateInput
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic hit;
  // Decode of every mapped offset; anything else must read as zero
  assign hit = regAddr inside {`GEC_OFS_CFG0, `GEC_OFS_CMD, `GEC_OFS_STATUS, `GEC_OFS_COUNT0,
    `GEC_OFS_COUNT1, `GEC_OFS_TBDIV, `GEC_OFS_CFG1};
  rd_idle_a: assert property (!regRdStb |=> regRdData_q == 32'h0)
    else $error("read data not zero outside a read");
  miss_read_a: assert property (regRdStb && !hit |=> regRdData_q == 32'h0)
    else $error("unmapped read not zero");
  cmd_read_a: assert property (regRdStb && regAddr == `GEC_OFS_CMD |=> regRdData_q == 32'h0)
    else $error("command register read not zero");
  cfg_width_a: assert property (
    regRdStb && (regAddr == `GEC_OFS_CFG0 || regAddr == `GEC_OFS_CFG1) |=> regRdData_q[31:5] == 27'h0)
    else $error("config read has stray bits");
  status_width_a: assert property (regRdStb && regAddr == `GEC_OFS_STATUS |=> regRdData_q[31:4] == 28'h0)
    else $error("status read has stray bits");
  cfg_back_a: assert property (
    regWrStb && regAddr == `GEC_OFS_CFG0 ##1 regRdStb && regAddr == `GEC_OFS_CFG0
    |=> regRdData_q == {27'h0, $past(regWrData[4:0], 2)})
    else $error("config 0 readback wrong");
  both_load_a: assert property (
    regWrStb && regAddr == `GEC_OFS_CFG1 && regWrData[5] ##1 regRdStb && regAddr == `GEC_OFS_CFG0
    |=> regRdData_q == {27'h0, $past(regWrData[4:0], 2)})
    else $error("joint config did not load counter 0");
  tbdiv_back_a: assert property (
    regWrStb && regAddr == `GEC_OFS_TBDIV ##1 regRdStb && regAddr == `GEC_OFS_TBDIV
    |=> regRdData_q == {16'h0, $past(regWrData[15:0], 2)})
    else $error("divider readback wrong");
  // Main scenarios reached
  start_c: cover property (regWrStb && regAddr == `GEC_OFS_CMD && regWrData[1:0] == 2'h3);
  count_c: cover property (regRdStb && regAddr == `GEC_OFS_COUNT1);
  gate_c: cover property ($rose(counterGateInput[0]) ##[1:20] $rose(counterEventInput[0]));
endmodule
`default_nettype wire

// >>> testbench/gec_pin_source.sv
// Bench model of the external event and gate signal sources
`timescale 1ns/1ns
`default_nettype none
module gec_pin_source (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Burst request and gate level from the bench
  input wire logic go,
  input wire logic [3:0] pulses,
  input wire logic [1:0] hold,
  input wire logic [1:0] gateLevel,
  // State and pins
  output logic busy,
  output logic [1:0] counterEventInput,
  output logic [1:0] counterGateInput
);
  logic [4:0] halves_q;
  logic [1:0] dwell_q;
  logic level_q;
  // Each level lasts hold+1 clocks, so slow and prompt sources both occur
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      halves_q <= 5'h00;
      dwell_q <= 2'h0;
      level_q <= 1'b0;
      counterGateInput <= 2'h0;
    end else begin
      counterGateInput <= gateLevel;
      if (go) begin
        halves_q <= {pulses, 1'b0};
        dwell_q <= 2'h0;
      end else if (halves_q != 5'h00) begin
        if (dwell_q == 2'h0) begin
          dwell_q <= hold;
          level_q <= ~level_q;
          halves_q <= halves_q - 5'h01;
        end else begin
          dwell_q <= dwell_q - 2'h1;
        end
      end
    end
  end
  // Both lanes carry one burst; a burst always ends low
  assign counterEventInput = {2{level_q}};
  assign busy = halves_q != 5'h00;
endmodule
`default_nettype wire

// >>> testbench/gated_event_counter_test.sv
// Self-checking bench for the gated event counter
`timescale 1ns/1ns
`default_nettype none
`include "gec_consts.vh"
module gated_event_counter_test;
  logic clk, sys_rst, regWrStb, regRdStb, go, busy;
  logic [`GEC_ADDR_W-1:0] regAddr;
  logic [31:0] regWrData, regRdData_q;
  logic [1:0] evt, gate, gLvl, hold;
  logic [3:0] pulses;
  integer err_total, checked, seed, m, p, n, e, i, expCnt, t0;
  gec_counter_top dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_q(regRdData_q), .counterEventInput(evt),
    .counterGateInput(gate));
  gec_pin_source src (.clk(clk), .sys_rst(sys_rst), .go(go), .pulses(pulses), .hold(hold),
    .gateLevel(gLvl), .busy(busy), .counterEventInput(evt), .counterGateInput(gate));
  // Verdict and end of run
  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bus cycles start just after an edge; a read allows a tolerance for free-running ticks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStb <= 1'b1;
    @(posedge clk);
    regWrStb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] tol = 0);
    regAddr <= a;
    regRdStb <= 1'b1;
    @(posedge clk);
    regRdStb <= 1'b0;
    #1;
    checked++;
    if ((^regRdData_q === 1'bx) || (regRdData_q - x + tol > 2 * tol)) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, regRdData_q, x);
    end
  endtask
  // Ask the source for k pulses, wait for it, then let the synchroniser drain
  task automatic burst(input integer k);
    pulses <= k[3:0];
    hold <= 2'($random(seed));
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (i = 0; busy; i++) begin
      if (i == 300) begin
        err_total++;
        test_done;
      end
      @(posedge clk);
      #1;
    end
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic gset(input logic [1:0] v);
    gLvl <= v;
    repeat (5) @(posedge clk);
    #1;
  endtask
  // Level modes count on odd phases, edge modes from the first gate change on
  function automatic bit counts(input integer md, input integer ph);
    if (md == 1 || md == 2) return ph[0];
    return md == 0 || ph > 0;
  endfunction
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    seed = 32'he199;
    err_total = 0;
    checked = 0;
    {sys_rst, regWrStb, regRdStb, go, regAddr, regWrData, pulses, hold, gLvl} = {4'h8, 48'h0};
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    #1;
    for (m = 0; m < 32; m += 4) rd(m[7:0], 32'h0);
    $display("reset test done");
    for (m = 0; m < 5; m++) begin
      e = $random(seed) & 1;
      wr(`GEC_OFS_CFG1, 32'h20 | (e << 3) | m);
      rd(`GEC_OFS_CFG0, (e << 3) | m);
      wr(`GEC_OFS_CMD, 32'h0c);
      gset({2{m == 2 || m == 4}});
      wr(`GEC_OFS_CMD, 32'h33);
      expCnt = 0;
      for (p = 0; p < 4; p++) begin
        if (p > 0) gset(~gLvl);
        n = 1 + ($unsigned($random(seed)) % 15);
        burst(n);
        if (counts(m, p)) expCnt += n;
      end
      rd(`GEC_OFS_COUNT0, expCnt);
      rd(`GEC_OFS_COUNT1, expCnt);
      $display("mode %0d test done", m);
    end
    wr(`GEC_OFS_CMD, 32'h0c);
    wr(`GEC_OFS_TBDIV, 32'h3);
    rd(`GEC_OFS_TBDIV, 32'h3);
    wr(`GEC_OFS_CFG0, 32'h10);
    rd(`GEC_OFS_CFG0, 32'h10);
    wr(`GEC_OFS_CMD, 32'h11);
    t0 = $time;
    rd(`GEC_OFS_STATUS, 32'h5);
    burst(6);
    wr(`GEC_OFS_CMD, 32'h04);
    rd(`GEC_OFS_COUNT0, ($time - t0) / 400 - 1, 2);
    rd(`GEC_OFS_STATUS, 32'h0);
    $display("timebase test done");
    test_done;
  end
endmodule
bind gec_counter_top gec_counter_monitor mon (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
  .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData_q(regRdData_q),
  .counterEventInput(counterEventInput), .counterGateInput(counterGateInput));
`default_nettype wire
